//--- rtl/voice_dac_pkg.sv
// Package with register map, field layouts and carrier types of the voice converter control
// Function
// (RULE_01) Low byte write only loads shadow buffer, converter value unchanged.
// (RULE_02) High byte write loads full 16-bit value and starts conversion cycle.
// (RULE_03) High byte write copies shadow buffer into low byte register simultaneously.
// (RULE_04) Software writes low byte first, then high byte.
// (RULE_05) High register holds bits 15..8, low holds 7..0; both read/write, reset zero.
// (RULE_06) Control bit 0 enables converter; resets to zero.
// (RULE_07) Control bits 7..1 ignore writes and read zero.
// (RULE_08) Software sets enable before writing new converter data.
// (RULE_09) Software waits settling time after enable before data update.
// (RULE_10) Low byte read returns committed low byte, not pending shadow.
package voice_dac_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h00;
  localparam logic [7:0] ADDR_DATA_LOW  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_SHADOW    = 8'h0c;
  localparam int         ADDR_W         = 8;
  // Field layout and reset values
  localparam int         ENABLE_BIT     = 0;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic [7:0] CONTROL_MASK   = 8'h01;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0] HTRANS_SEQ     = 2'h3;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;
  // Converter drive bundle
  typedef struct packed {
    logic        enable;
    logic [15:0] code;
    logic        start;
  } dac_drive_t;
  // Decoded register select
  typedef struct packed {
    logic high;
    logic low;
    logic ctrl;
    logic shadow;
  } reg_sel_t;
endpackage

//--- rtl/dac_data_latch.sv
// Shadow buffer and committed 16-bit converter code
`timescale 1ns/10ps
module dac_data_latch
  import voice_dac_pkg::*;
(
  input  wire logic        hclk,        // System clock
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        wr_low,      // Low byte write strobe
  input  wire logic        wr_high,     // High byte write strobe
  input  wire logic [7:0]  wdata,       // Write byte
  output logic      [7:0]  shadow,      // Pending low byte
  output logic      [15:0] code,        // Committed code
  output logic             start        // Conversion start pulse
);
  logic [7:0]  shadow_r, shadow_nxt;
  logic [15:0] code_r, code_nxt;
  logic        start_r, start_nxt;

  // Next values of shadow and committed code
  always_comb
  begin
    shadow_nxt = shadow_r;
    code_nxt   = code_r;
    start_nxt  = 1'b0;
    if (wr_low)
      shadow_nxt = wdata;                 // RULE_01
    if (wr_high)
    begin
      code_nxt  = {wdata, shadow_r};      // RULE_02 RULE_03
      start_nxt = 1'b1;                   // RULE_02
    end
  end

  // Registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shadow_r <= BYTE_RESET;
      code_r   <= {BYTE_RESET, BYTE_RESET};
      start_r  <= 1'b0;
    end
    else
    begin
      shadow_r <= shadow_nxt;
      code_r   <= code_nxt;
      start_r  <= start_nxt;
    end
  end

  assign shadow = shadow_r;
  assign code   = code_r;
  assign start  = start_r;

  // Low byte write leaves the committed code alone
  a_low_no_commit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (wr_low && !wr_high) |=> (code_r == $past(code_r)))
    else $error("low byte write changed committed code");
  // High byte write commits both bytes
  a_high_commit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    wr_high |=> (code_r == {$past(wdata), $past(shadow_r)}) && start_r)
    else $error("high byte write did not commit shadow");
  // Start pulse only after a high write
  a_start_cause: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    start_r |-> $past(wr_high))
    else $error("start pulse without high write");
endmodule // dac_data_latch

//--- rtl/voice_dac_register_control.sv
// AHB-Lite register slave driving the 16-bit voice converter
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
module voice_dac_register_control
  import voice_dac_pkg::*;
(
  input  wire logic        hclk,        // System clock 125 MHz
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        hsel,        // Slave select
  input  wire logic [31:0] haddr,       // Byte address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write when high
  input  wire logic [2:0]  hsize,       // Transfer size
  input  wire logic [31:0] hwdata,      // Write data
  input  wire logic        hready,      // Bus ready in
  output logic      [31:0] hrdata,      // Read data
  output logic             hreadyout,   // Slave ready, always high
  output logic             hresp,       // Always OKAY
  output dac_drive_t       dac_drive    // Enable, code and start to converter
);
  // Address phase capture
  logic             wr_pend_r, wr_pend_nxt;
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [31:0]      hrdata_r, hrdata_nxt;
  logic             enable_r, enable_nxt;
  logic             en_out_r;
  logic [7:0]       shadow;
  logic [15:0]      code;
  logic             start;
  logic             wr_low, wr_high;
  logic             phase_ok;
  reg_sel_t         wsel, rsel;

  // Decode a byte address into register selects
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s.high   = (a == ADDR_DATA_HIGH);
    s.low    = (a == ADDR_DATA_LOW);
    s.ctrl   = (a == ADDR_CONTROL);
    s.shadow = (a == ADDR_SHADOW);
    return s;
  endfunction

  // Valid address phase of a transfer of any size, hsize not checked
  assign phase_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rsel     = decode(haddr[ADDR_W-1:0]);
  assign wsel     = decode(wr_addr_r);
  assign wr_low   = wr_pend_r && wsel.low;
  assign wr_high  = wr_pend_r && wsel.high;

  // Bus next-state: write capture and read data
  always_comb
  begin
    wr_pend_nxt = phase_ok && hwrite;
    wr_addr_nxt = phase_ok ? haddr[ADDR_W-1:0] : wr_addr_r;
    enable_nxt  = enable_r;
    if (wr_pend_r && wsel.ctrl)
      enable_nxt = hwdata[ENABLE_BIT];    // RULE_06
    hrdata_nxt = 32'h0000_0000;
    if (phase_ok && !hwrite)
    begin
      if (rsel.high)
        hrdata_nxt = {24'h00_0000, code[15:8]};              // RULE_05
      else if (rsel.low)
        hrdata_nxt = {24'h00_0000, code[7:0]};               // RULE_10
      else if (rsel.ctrl)
        hrdata_nxt = {24'h00_0000, {7'h00, enable_r} & CONTROL_MASK}; // RULE_07
      else if (rsel.shadow)
        hrdata_nxt = {24'h00_0000, shadow};
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r  <= 32'h0000_0000;
      enable_r  <= 1'b0;                  // RULE_06
      en_out_r  <= 1'b0;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
      enable_r  <= enable_nxt;
      en_out_r  <= enable_nxt;
    end
  end

  // Data path holding shadow and committed code
  dac_data_latch u_latch (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_low  (wr_low),
    .wr_high (wr_high),
    .wdata   (hwdata[7:0]),
    .shadow  (shadow),
    .code    (code),
    .start   (start)
  );

  assign hrdata           = hrdata_r;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign dac_drive.enable = en_out_r;
  assign dac_drive.code   = code;
  assign dac_drive.start  = start;

  // Control reads never show upper bits
  a_ctrl_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    $past(phase_ok && !hwrite && rsel.ctrl) |-> (hrdata_r[31:1] == 31'h0))
    else $error("control upper bits not zero");
  // Enable follows bit 0 of a control write
  a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    (wr_pend_r && wsel.ctrl) |=> (enable_r == $past(hwdata[ENABLE_BIT])))
    else $error("enable bit not written");
  // Low read returns committed byte
  a_low_read: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    (phase_ok && !hwrite && rsel.low) |=> (hrdata_r[7:0] == $past(code[7:0])))
    else $error("low read not committed byte");
  // High read returns committed high byte
  a_high_read: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    (phase_ok && !hwrite && rsel.high) |=> (hrdata_r == {24'h0, $past(code[15:8])}))
    else $error("high read wrong");
  // Low write leaves converter code unchanged into the next cycle
  a_low_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (wr_low && !wr_high) |=> (dac_drive.code == $past(dac_drive.code)))
    else $error("low write moved converter code");
  // High write starts a one-cycle pulse, longer only if another high write follows
  a_start_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    wr_high |=> dac_drive.start ##1 (!dac_drive.start || $past(wr_high)))
    else $error("start pulse wrong");
  // Commit places shadow in low byte
  a_commit_low: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    wr_high |=> (dac_drive.code[7:0] == $past(shadow)))
    else $error("shadow not copied");
  // Ready never drops
  a_ready_high: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    hreadyout && !hresp)
    else $error("ready or resp wrong");

  // Read data is zero outside a read data phase
  a_idle_rdata: assert property (@(posedge hclk) disable iff (!hresetn)
    !(phase_ok && !hwrite)
    |=> (hrdata_r == 32'h0000_0000))
    else $error("read data not zero when idle");

  // Upper read data bits always zero
  a_rdata_upper: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    1'b1
    |-> (hrdata_r[31:8] == 24'h00_0000))
    else $error("read data upper bits not zero");

  // Shadow readback shows pending low byte
  a_shadow_read: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (phase_ok && !hwrite && rsel.shadow)
    |=> (hrdata_r == {24'h00_0000, $past(shadow)}))
    else $error("shadow readback wrong");

  // Control read returns enable in bit 0
  a_ctrl_read: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    (phase_ok && !hwrite && rsel.ctrl)
    |=> (hrdata_r == {31'h0000_0000, $past(enable_r)}))
    else $error("control readback wrong");

  // Unmapped read returns zero
  a_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_ok && !hwrite && !(|rsel))
    |=> (hrdata_r == 32'h0000_0000))
    else $error("unmapped read not zero");

  // Enable only moves on a control write
  a_enable_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    !(wr_pend_r && wsel.ctrl)
    |=> $stable(enable_r))
    else $error("enable moved without control write");

  // Converter enable output tracks the register
  a_enable_out: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    1'b1
    |-> (dac_drive.enable == enable_r))
    else $error("enable output differs");

  // Code only moves on a high byte write
  a_code_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    !wr_high
    |=> $stable(code))
    else $error("code moved without high write");

  // Shadow only moves on a low byte write
  a_shadow_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    !wr_low
    |=> $stable(shadow))
    else $error("shadow moved without low write");

  // Low byte write loads the shadow
  a_shadow_load: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    wr_low
    |=> (shadow == $past(hwdata[7:0])))
    else $error("shadow not loaded");

  // High byte write places data in bits 15..8
  a_code_high: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    wr_high
    |=> (code[15:8] == $past(hwdata[7:0])))
    else $error("high byte not committed");

  // Write address phase opens a data phase
  a_write_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_ok && hwrite)
    |=> wr_pend_r)
    else $error("write not captured");

  // No write data phase without a write address phase
  a_no_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    !(phase_ok && hwrite)
    |=> !wr_pend_r)
    else $error("spurious write data phase");

  // Start pulse lasts one cycle unless another commit follows
  a_start_once: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    dac_drive.start
    |=> (!dac_drive.start || $past(wr_high)))
    else $error("start pulse too long");

  // Low byte write never starts a conversion
  a_low_no_start: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    wr_low
    |=> !dac_drive.start)
    else $error("low write started conversion");

  // Writes to the shadow readback place are ignored
  a_shadow_wr_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && wsel.shadow)
    |=> ($stable(shadow) && $stable(code)))
    else $error("shadow place write took effect");

  // Control write leaves the code alone
  a_ctrl_no_code: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    (wr_pend_r && wsel.ctrl)
    |=> $stable(code))
    else $error("control write moved code");

  // Read address phase opens no write
  a_read_no_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_ok && !hwrite)
    |=> !wr_pend_r)
    else $error("read opened a write");

  // Address captured in each valid address phase
  a_addr_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_ok
    |=> (wr_addr_r == $past(haddr[ADDR_W-1:0])))
    else $error("address not captured");

  // Address held outside address phases
  a_addr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !phase_ok
    |=> $stable(wr_addr_r))
    else $error("address moved when idle");
endmodule // voice_dac_register_control

//--- tb/testbench.sv
// Self-checking bench for the voice converter register control over AHB-Lite
`timescale 1ns/10ps
module testbench;
  import voice_dac_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  dac_drive_t  dac_drive;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [31:0] seed = 32'd55650;
  logic [31:0] rd;
  logic [7:0]  lo, hi, old_lo, old_hi, ctl;
  localparam int SETTLE_CYCLES = 16; // Converter settle wait, plain default
  voice_dac_register_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dac_drive(dac_drive));
  // Clock, 8 ns period
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Xorshift random source with fixed start
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected converter code and control readback
  function automatic logic [15:0] code_of(input logic [7:0] h, input logic [7:0] l);
    return {h, l};
  endfunction
  function automatic logic [31:0] ctl_of(input logic [7:0] d);
    return {24'h0, 7'h0, d[0]};
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer, waiting on hreadyout for both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hwrite <= w;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
    #1;
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
  // Main sequence
  initial
  begin
    hresetn = 1'b0; hsel = 1'b1; hready = 1'b1; hsize = HSIZE_WORD;
    haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values of high, low and control registers
    xfer(1'b0, ADDR_DATA_HIGH, 32'h0, rd); chk(rd, 32'h0);
    xfer(1'b0, ADDR_DATA_LOW, 32'h0, rd); chk(rd, 32'h0);
    xfer(1'b0, ADDR_CONTROL, 32'h0, rd); chk(rd, 32'h0);
    chk({14'h0, dac_drive}, 32'h0);
    $display("test reset done");
    // Disable once, then enable, with upper control bits set, then readback
    foreach (ctl[i])
    begin
      seed = xs(seed);
      ctl = seed[7:0] | 8'hfe;
      ctl[0] = (i != 7);
      xfer(1'b1, ADDR_CONTROL, {seed[31:8], ctl}, rd);
      xfer(1'b0, ADDR_CONTROL, 32'h0, rd); chk(rd, ctl_of(ctl));
      chk({31'h0, dac_drive.enable}, {31'h0, ctl[0]});
    end
    repeat (SETTLE_CYCLES) @(posedge hclk);
    $display("test control done");
    // Low then high writes, random values with corner bytes
    old_lo = 8'h00; old_hi = 8'h00;
    for (int k = 0; k < 24; k++)
    begin
      seed = xs(seed);
      lo = (k == 0) ? 8'hff : seed[7:0];
      hi = (k == 1) ? 8'h80 : seed[15:8];
      xfer(1'b1, ADDR_DATA_LOW, {seed[31:16], 8'h00, lo}, rd);
      chk({16'h0, dac_drive.code}, {16'h0, code_of(old_hi, old_lo)});
      xfer(1'b0, ADDR_DATA_LOW, 32'h0, rd); chk(rd, {24'h0, old_lo});
      xfer(1'b0, ADDR_SHADOW, 32'h0, rd); chk(rd, {24'h0, lo});
      xfer(1'b1, ADDR_DATA_HIGH, {seed[31:16], 8'h00, hi}, rd);
      chk({31'h0, dac_drive.start}, 32'h1);
      chk({16'h0, dac_drive.code}, {16'h0, code_of(hi, lo)});
      @(posedge hclk); #1;
      chk({31'h0, dac_drive.start}, 32'h0);
      xfer(1'b0, ADDR_DATA_LOW, 32'h0, rd); chk(rd, {24'h0, lo});
      xfer(1'b0, ADDR_DATA_HIGH, 32'h0, rd); chk(rd, {24'h0, hi});
      old_lo = lo; old_hi = hi;
    end
    $display("test data done");
    // Unmapped place reads zero, write there has no effect
    xfer(1'b1, 8'h10, 32'hffffffff, rd);
    xfer(1'b0, 8'h10, 32'h0, rd); chk(rd, 32'h0);
    chk({16'h0, dac_drive.code}, {16'h0, code_of(old_hi, old_lo)});
    $display("test unmapped done");
    conclude();
  end
endmodule // testbench
